// [ftbs_pkg.sv]
package ftbs_pkg;

   // ****************************************************************
   // Timing and reset values
   // ****************************************************************

   // Entering or leaving sleep takes this many clock cycles.
   localparam int unsigned SLEEP_ENTER_CYC = 2;
   localparam int unsigned SLEEP_EXIT_CYC  = 2;
   localparam int unsigned SLEEP_CNT_W     = 2;

   localparam logic [1:0] BURST_CNT_RST = 2'h0;
   localparam logic [1:0] BURST_CNT_INC = 2'h1;
   localparam logic       OE_N_RST      = 1'b1;

   // Number of pin-side synchroniser stages.
   localparam int unsigned SYNC_STAGES = 2;

   // ****************************************************************
   // Types
   // ****************************************************************

   // Control pins sampled together on each clock edge.
   typedef struct packed {
      logic clock_qualify_n;
      logic chip_select_1_n;
      logic chip_select_2;
      logic chip_select_3_n;
      logic load_or_advance;
      logic write_en_n;
      logic burst_order;
      logic output_enable_n;
      logic sleep_request;
   } ftbs_ctrl_s;

   localparam ftbs_ctrl_s CTRL_IDLE = '{
      clock_qualify_n : 1'b1,
      chip_select_1_n : 1'b1,
      chip_select_2   : 1'b0,
      chip_select_3_n : 1'b1,
      load_or_advance : 1'b0,
      write_en_n      : 1'b1,
      burst_order     : 1'b0,
      output_enable_n : 1'b1,
      sleep_request   : 1'b0
   };

   typedef enum logic [1:0] {
      SLP_AWAKE,
      SLP_ENTERING,
      SLP_ASLEEP,
      SLP_LEAVING
   } ftbs_sleep_e;

endpackage : ftbs_pkg

// [ftbs_sram.sv]
`timescale 1ns/1ps

// Notes on behaviour
// - Qualifier high: edge ignored, state held.
// - Load, qualify, all selects start access.
// - Write strobe high: read, data three edges later.
// - Read data driven only while enable low.
// - Deselect on load releases bus at once.
// - Next operation accepted right after read.
// - Burst counter cycles over four addresses.
// - Two low bits wrap; linear or interleaved.
// - Advance strobe high ignores selects, write.
// - Direction latched at burst start only.
// - Write start latches controls, releases bus.
// - Write data taken on following edge.
// - Only selected byte lanes get written.
// - Sleep asynchronous; two cycles in, out.
// - Array kept while asleep; access dropped.
// - Linear adds count; interleaved XORs count.
// - Output enable masked during write phases.
// - No lane selected: write abort, bus released.
module ftbs_sram
   import ftbs_pkg::*;
#(
   parameter int unsigned ADDR_W = 19,
   parameter int unsigned LANES  = 4,
   parameter int unsigned LANE_W = 8
)(
   input  wire logic                      clk,
   input  wire logic                      srst,
   input  wire ftbs_ctrl_s                ctrl_pins,
   input  wire logic [ADDR_W-1:0]         address,
   input  wire logic [LANES-1:0]          byte_lane_write_n,
   input  wire logic [LANES*LANE_W-1:0]   data_in,
   input  wire logic [LANES-1:0]          parity_lines_in,
   output logic      [LANES*LANE_W-1:0]   data_out,
   output logic      [LANES-1:0]          parity_lines_out,
   output logic                           data_oe_n,
   output logic                           asleep
);

   localparam int unsigned WORD_W  = LANES * (LANE_W + 1);
   localparam int unsigned DEPTH   = 1 << ADDR_W;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   // Every pin, including the asynchronous enable and sleep request,
   // passes two flops. All pins share the same delay, so the sampled
   // set still describes one and the same edge of the controller.
   ftbs_ctrl_s                ctl_m_r,  ctl_s_r;
   logic [ADDR_W-1:0]         adr_m_r,  adr_s_r;
   logic [LANES-1:0]          bw_m_r,   bw_s_r;
   logic [LANES*LANE_W-1:0]   dat_m_r,  dat_s_r;
   logic [LANES-1:0]          par_m_r,  par_s_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctl_m_r <= CTRL_IDLE;
         ctl_s_r <= CTRL_IDLE;
         adr_m_r <= '0;
         adr_s_r <= '0;
         bw_m_r  <= '1;
         bw_s_r  <= '1;
         dat_m_r <= '0;
         dat_s_r <= '0;
         par_m_r <= '0;
         par_s_r <= '0;
      end
      else
      begin
         ctl_m_r <= ctrl_pins;
         ctl_s_r <= ctl_m_r;
         adr_m_r <= address;
         adr_s_r <= adr_m_r;
         bw_m_r  <= byte_lane_write_n;
         bw_s_r  <= bw_m_r;
         dat_m_r <= data_in;
         dat_s_r <= dat_m_r;
         par_m_r <= parity_lines_in;
         par_s_r <= par_m_r;
      end
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************

   function automatic logic [1:0] burst_step(input logic [1:0] base,
                                             input logic [1:0] cnt,
                                             input logic       ilv);
      burst_step = ilv ? (base ^ cnt) : 2'(base + cnt);
   endfunction

   // ****************************************************************
   // Sleep control
   // ****************************************************************

   ftbs_sleep_e               slp_r,    slp_nxt;
   logic [SLEEP_CNT_W-1:0]    scnt_r,   scnt_nxt;
   logic                      awake;

   always_comb
   begin
      slp_nxt  = slp_r;
      scnt_nxt = scnt_r;
      case (slp_r)
         SLP_AWAKE:
            if (ctl_s_r.sleep_request)
            begin
               slp_nxt  = SLP_ENTERING;
               scnt_nxt = SLEEP_CNT_W'(SLEEP_ENTER_CYC - 1);
            end
         SLP_ENTERING:
            if (scnt_r == '0)
               slp_nxt = SLP_ASLEEP;
            else
               scnt_nxt = scnt_r - 1'b1;
         SLP_ASLEEP:
            if (!ctl_s_r.sleep_request)
            begin
               slp_nxt  = SLP_LEAVING;
               scnt_nxt = SLEEP_CNT_W'(SLEEP_EXIT_CYC - 1);
            end
         SLP_LEAVING:
            if (scnt_r == '0)
               slp_nxt = SLP_AWAKE;
            else
               scnt_nxt = scnt_r - 1'b1;
         default:
            slp_nxt = SLP_AWAKE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         slp_r  <= SLP_AWAKE;
         scnt_r <= '0;
      end
      else
      begin
         slp_r  <= slp_nxt;
         scnt_r <= scnt_nxt;
      end
   end

   // Sleep takes hold at once; the request is not held off by a stall.
   assign awake = (slp_r == SLP_AWAKE) && !ctl_s_r.sleep_request;

   // ****************************************************************
   // Access control
   // ****************************************************************

   logic                      act_r,    act_nxt;
   logic                      wr_r,     wr_nxt;
   logic                      ilv_r,    ilv_nxt;
   logic [ADDR_W-1:0]         base_r,   base_nxt;
   logic [1:0]                cnt_r,    cnt_nxt;
   logic                      wpend_r,  wpend_nxt;
   logic [ADDR_W-1:0]         waddr_r,  waddr_nxt;
   logic [LANES-1:0]          wbe_n_r,  wbe_n_nxt;
   logic                      rdg_r,    rdg_nxt;
   logic                      rd_en;
   logic [ADDR_W-1:0]         rd_addr;
   logic                      wr_en;
   logic                      qual;
   logic                      sel_all;

   assign qual    = awake && !ctl_s_r.clock_qualify_n;
   assign sel_all = !ctl_s_r.chip_select_1_n && ctl_s_r.chip_select_2
                    && !ctl_s_r.chip_select_3_n;

   always_comb
   begin
      act_nxt   = act_r;
      wr_nxt    = wr_r;
      ilv_nxt   = ilv_r;
      base_nxt  = base_r;
      cnt_nxt   = cnt_r;
      wpend_nxt = wpend_r;
      waddr_nxt = waddr_r;
      wbe_n_nxt = wbe_n_r;
      rdg_nxt   = rdg_r;
      rd_en     = 1'b0;
      rd_addr   = adr_s_r;
      wr_en     = 1'b0;
      if (!awake)
      begin
         // Whatever was pending is dropped; the array is untouched.
         act_nxt   = 1'b0;
         wpend_nxt = 1'b0;
         rdg_nxt   = 1'b0;
      end
      else if (qual)
      begin
         // Data phase of the previous write completes on this edge.
         wr_en     = wpend_r;
         wpend_nxt = 1'b0;
         rdg_nxt   = 1'b0;
         if (!ctl_s_r.load_or_advance)
         begin
            if (sel_all)
            begin
               act_nxt  = 1'b1;
               wr_nxt   = !ctl_s_r.write_en_n;
               ilv_nxt  = ctl_s_r.burst_order;
               base_nxt = adr_s_r;
               cnt_nxt  = BURST_CNT_RST;
               if (ctl_s_r.write_en_n)
               begin
                  rd_en   = 1'b1;
                  rdg_nxt = 1'b1;
               end
               else
               begin
                  wpend_nxt = 1'b1;
                  waddr_nxt = adr_s_r;
                  wbe_n_nxt = bw_s_r;
               end
            end
            else
               act_nxt = 1'b0;
         end
         else if (act_r)
         begin
            // Selects and write strobe are not looked at here.
            cnt_nxt = cnt_r + BURST_CNT_INC;
            rd_addr = {base_r[ADDR_W-1:2],
                       burst_step(base_r[1:0], cnt_nxt, ilv_r)};
            if (!wr_r)
            begin
               rd_en   = 1'b1;
               rdg_nxt = 1'b1;
            end
            else
            begin
               wpend_nxt = 1'b1;
               waddr_nxt = rd_addr;
               wbe_n_nxt = bw_s_r;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         act_r   <= 1'b0;
         wr_r    <= 1'b0;
         ilv_r   <= 1'b0;
         base_r  <= '0;
         cnt_r   <= BURST_CNT_RST;
         wpend_r <= 1'b0;
         waddr_r <= '0;
         wbe_n_r <= '1;
         rdg_r   <= 1'b0;
      end
      else
      begin
         act_r   <= act_nxt;
         wr_r    <= wr_nxt;
         ilv_r   <= ilv_nxt;
         base_r  <= base_nxt;
         cnt_r   <= cnt_nxt;
         wpend_r <= wpend_nxt;
         waddr_r <= waddr_nxt;
         wbe_n_r <= wbe_n_nxt;
         rdg_r   <= rdg_nxt;
      end
   end

   // ****************************************************************
   // Array and output drivers
   // ****************************************************************

   // Each lane stores its byte with its parity bit on top.
   logic [WORD_W-1:0]         mem [DEPTH];
   logic [WORD_W-1:0]         rword_r;
   logic                      oe_n_r,   oe_n_nxt;

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (!wbe_n_r[i])
               mem[waddr_r][i*(LANE_W+1) +: (LANE_W+1)] <=
                  {par_s_r[i], dat_s_r[i*LANE_W +: LANE_W]};
         end
      end
      if (rd_en)
      begin
         // The array write above only lands after this edge, so a word
         // written on this same edge is forwarded lane by lane; a read
         // right behind a write then sees the new bytes.
         for (int i = 0; i < LANES; i++)
            rword_r[i*(LANE_W+1) +: (LANE_W+1)] <=
               (wr_en && !wbe_n_r[i] && (waddr_r == rd_addr)) ?
               {par_s_r[i], dat_s_r[i*LANE_W +: LANE_W]} :
               mem[rd_addr][i*(LANE_W+1) +: (LANE_W+1)];
      end
   end

   // The enable pin is asynchronous, so it is rechecked every cycle,
   // also while the edge is stalled; the write phase masks it.
   always_comb
   begin
      oe_n_nxt = !(rdg_nxt && !ctl_s_r.output_enable_n);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         oe_n_r <= OE_N_RST;
      else
         oe_n_r <= oe_n_nxt;
   end

   always_comb
   begin
      for (int i = 0; i < LANES; i++)
      begin
         data_out[i*LANE_W +: LANE_W] = rword_r[i*(LANE_W+1) +: LANE_W];
         parity_lines_out[i]          = rword_r[i*(LANE_W+1) + LANE_W];
      end
   end

   assign data_oe_n = oe_n_r;

   always_ff @(posedge clk)
   begin
      if (srst)
         asleep <= 1'b0;
      else
         asleep <= (slp_nxt == SLP_ASLEEP);
   end

endmodule // ftbs_sram

// [ftbs_sram_properties.sv]
`timescale 1ns/1ps
module ftbs_sram_properties
   import ftbs_pkg::*;
#(
   parameter int unsigned LANES  = 4,
   parameter int unsigned LANE_W = 8
)(
   input wire logic                    clk,
   input wire logic                    srst,
   input wire ftbs_ctrl_s              ctrl_pins,
   input wire logic [LANES*LANE_W-1:0] data_out,
   input wire logic                    data_oe_n,
   input wire logic                    asleep
);
   // ****
   // A command at the pins shows at the outputs three edges later.
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic ld;
   logic sel;
   assign ld = !ctrl_pins.clock_qualify_n && !ctrl_pins.load_or_advance;
   assign sel = !ctrl_pins.chip_select_1_n && ctrl_pins.chip_select_2 &&
      !ctrl_pins.chip_select_3_n;
   a_reset_quiet: assert property (
      $fell(srst) |-> data_oe_n && !asleep) else $error("busy after reset");
   a_read_drives: assert property (
      ld && sel && ctrl_pins.write_en_n && !ctrl_pins.output_enable_n
      |-> ##3 !data_oe_n) else $error("read not driven");
   a_write_quiet: assert property (
      ld && sel && !ctrl_pins.write_en_n |-> ##3 data_oe_n)
      else $error("bus driven on write");
   a_desel_quiet: assert property (
      ld && !sel |-> ##3 data_oe_n) else $error("bus driven deselected");
   a_oe_release: assert property (
      ctrl_pins.output_enable_n [*4] |-> data_oe_n)
      else $error("bus driven with enable off");
   a_stall_hold: assert property (
      (ctrl_pins.clock_qualify_n && !ctrl_pins.output_enable_n) [*6]
      |-> $stable(data_out) && $stable(data_oe_n)) else $error("stall moved");
   a_sleep_entry: assert property (
      ctrl_pins.sleep_request [*7] |-> asleep && data_oe_n)
      else $error("sleep not entered");
   a_sleep_exit: assert property (
      !ctrl_pins.sleep_request [*7] |-> !asleep) else $error("still asleep");
   c_read: cover property (ld && sel && ctrl_pins.write_en_n ##3 !data_oe_n);
   c_write: cover property (ld && sel && !ctrl_pins.write_en_n);
   c_sleep: cover property ($rose(asleep));
endmodule // ftbs_sram_properties

// [ftbs_ctl_model.sv]
`timescale 1ns/1ps
module ftbs_ctl_model
   import ftbs_pkg::*;
(
   input wire logic    clk,
   output ftbs_ctrl_s  ctrl_pins,
   output logic [18:0] address,
   output logic [3:0]  byte_lane_write_n,
   output logic [31:0] data_in,
   output logic [3:0]  parity_lines_in
);
   // ****
   // Controller side: write data trails its command by one edge.
   // ****
   logic        wr_pend = 1'b0;
   logic [35:0] wr_val;
   initial
   begin
      ctrl_pins = CTRL_IDLE;
      address = 19'h0_0000;
      byte_lane_write_n = 4'hF;
      {parity_lines_in, data_in} = 36'h0_0000_0000;
   end
   task automatic step(input ftbs_ctrl_s c, input logic [18:0] a,
      input logic [3:0] bw, input logic wr, input logic [35:0] wd);
      @(posedge clk);
      #1 ctrl_pins = c;
      address = a;
      byte_lane_write_n = bw;
      // Idle lines toggle so that a capture of stale data cannot pass.
      if (wr_pend)
         {parity_lines_in, data_in} = wr_val;
      else
         {parity_lines_in, data_in} = ~{parity_lines_in, data_in};
      if (!c.clock_qualify_n)
      begin
         wr_pend = wr;
         wr_val = wd;
      end
   endtask
   task automatic sleep(input logic s);
      @(posedge clk);
      #1 ctrl_pins.sleep_request = s;
   endtask
endmodule // ftbs_ctl_model

// [tb_ftbs_sram.sv]
`timescale 1ns/1ps
module tb_ftbs_sram;
   import ftbs_pkg::*;
   logic        clk, srst, data_oe_n, asleep, brst, ord, rd_dir;
   ftbs_ctrl_s  ctrl_pins;
   logic [18:0] address;
   logic [3:0]  byte_lane_write_n, parity_lines_in, parity_lines_out;
   logic [31:0] data_in, data_out;
   logic [35:0] mem [int];
   logic [36:0] exq [int];
   logic [36:0] last_out;
   int          error_cnt, num_checks, cyc, base, cnt;
   int          seed = 32'ha821_b514;
   ftbs_ctl_model ctl_u (.clk(clk), .ctrl_pins(ctrl_pins), .address(address),
      .byte_lane_write_n(byte_lane_write_n), .data_in(data_in),
      .parity_lines_in(parity_lines_in));
   ftbs_sram dut_u (.clk(clk), .srst(srst), .ctrl_pins(ctrl_pins),
      .address(address), .byte_lane_write_n(byte_lane_write_n),
      .data_in(data_in), .parity_lines_in(parity_lines_in),
      .data_out(data_out), .parity_lines_out(parity_lines_out),
      .data_oe_n(data_oe_n), .asleep(asleep));
   // ****
   // Reference model: each pin cycle fixes the bus three cycles later.
   // ****
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task automatic chk(input logic [36:0] got, input logic [36:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(negedge clk)
      if (exq.exists(cyc))
         chk({~data_oe_n, exq[cyc][36] ? {parity_lines_out, data_out}
            : 36'h0_0000_0000}, exq[cyc]);
   // Sel 0 selects the device; 1 to 3 drops one chip select.
   task automatic op(input int sel, input logic lda, input logic we_n,
      input logic oe_n, input logic [3:0] bw, input int ad,
      input logic q = 1'b0);
      ftbs_ctrl_s  c;
      logic [35:0] wd;
      logic [36:0] o;
      int          a;
      c = CTRL_IDLE;
      c.clock_qualify_n = q;
      c.chip_select_1_n = (sel == 1);
      c.chip_select_2 = (sel != 2);
      c.chip_select_3_n = (sel == 3);
      c.load_or_advance = lda;
      c.write_en_n = we_n;
      c.burst_order = ord;
      c.output_enable_n = oe_n;
      wd = 36'({$random(seed), $random(seed)});
      o = 37'h0;
      if (q)
         o = last_out;
      else if (!lda)
      begin
         brst = (sel == 0);
         base = ad;
         cnt = 0;
         rd_dir = we_n;
      end
      else if (brst)
         cnt = (cnt + 1) % 4;
      a = ord ? base ^ cnt : (base & ~3) | ((base + cnt) & 3);
      if (!q && brst && rd_dir && !oe_n)
         o = {1'b1, mem[a]};
      if (!q && brst && !rd_dir)
         for (int i = 0; i < 4; i++)
            if (!bw[i])
            begin
               mem[a][8*i +: 8] = wd[8*i +: 8];
               mem[a][32+i] = wd[32+i];
            end
      ctl_u.step(c, 19'(ad), bw, !q && brst && !rd_dir, wd);
      exq[cyc + 3] = o;
      last_out = o;
   endtask
   task automatic final_report();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (1000) @(posedge clk);
      error_cnt++;
      final_report();
   end
   initial
   begin
      srst = 1'b1;
      brst = 1'b0;
      last_out = 37'h0;
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      @(negedge clk);
      chk({~data_oe_n, asleep, 35'h0}, 37'h0);
      for (int m = 0; m < 2; m++)
      begin
         ord = m[0];
         op(0, 0, 0, 0, 4'h0, 17 + 5 * m);
         repeat (3) op(0, 1, 0, 0, 4'h0, 0);
         op(0, 0, 1, 0, 4'h0, 17 + 5 * m);
         repeat (3) op(m + 1, 1, 0, 0, 4'h0, 0);
      end
      for (int k = 0; k < 6; k++)
      begin
         op(0, 0, 0, 1, (k == 0) ? 4'hF : 4'($random(seed)), 17);
         op(1, 0, 1, 0, 4'h0, 0);
         op(0, 0, 1, 0, 4'h0, 17);
         op(0, 0, 0, 1, 4'($random(seed)), 17);
         op(0, 0, 1, 0, 4'h0, 17);
      end
      for (int s = 1; s < 4; s++)
      begin
         op(0, 0, 1, 0, 4'h0, 18);
         op(s, 0, 1, 0, 4'h0, 18);
         op(0, 1, 1, 0, 4'h0, 0);
      end
      op(0, 0, 1, 1, 4'h0, 19);
      op(0, 0, 1, 0, 4'h0, 22);
      repeat (6) op(0, 1, 1, 0, 4'h0, 0, 1'b1);
      repeat (3) op(0, 1, 1, 0, 4'h0, 0);
      op(1, 0, 1, 1, 4'h0, 0);
      ctl_u.sleep(1'b1);
      repeat (7) @(posedge clk);
      @(negedge clk);
      chk({asleep, ~data_oe_n, 35'h0}, {2'b10, 35'h0});
      ctl_u.sleep(1'b0);
      repeat (7) @(posedge clk);
      @(negedge clk);
      chk({asleep, 36'h0}, 37'h0);
      repeat (2) op(2, 0, 1, 0, 4'h0, 0);
      for (int j = 16; j < 24; j++)
         op(0, 0, 1, 0, 4'h0, j);
      repeat (4) @(posedge clk);
      final_report();
   end
endmodule // tb_ftbs_sram
bind ftbs_sram ftbs_sram_properties #(.LANES(LANES), .LANE_W(LANE_W)) chk_u (
   .clk(clk), .srst(srst), .ctrl_pins(ctrl_pins), .data_out(data_out),
   .data_oe_n(data_oe_n), .asleep(asleep));
